// >>> tmon_map.svh
// Purpose: register offsets, field positions, reset values and counts of the temperature monitor
// Assumes: byte-wide register port with an 8-bit address
// Notes: definitions only
`ifndef TMON_MAP_SVH
`define TMON_MAP_SVH

// read addresses
`define TM_RD_LVAL 8'h00
`define TM_RD_RVAL 8'h01
`define TM_RD_STATUS 8'h02
`define TM_RD_CFG 8'h03
`define TM_RD_RATE 8'h04
`define TM_RD_LHI 8'h05
`define TM_RD_LLO 8'h06
`define TM_RD_RHI 8'h07
`define TM_RD_RLO 8'h08
// write addresses
`define TM_WR_CFG 8'h09
`define TM_WR_RATE 8'h0A
`define TM_WR_LHI 8'h0B
`define TM_WR_LLO 8'h0C
`define TM_WR_RHI 8'h0D
`define TM_WR_RLO 8'h0E
// interrupt block
`define TM_IRQ_STAT 8'h20
`define TM_IRQ_CLR 8'h21
`define TM_IRQ_EN 8'h22

// reset values
`define TM_VAL_RST 8'h80
`define TM_CFG_RST 8'h00
`define TM_RATE_RST 8'h02
`define TM_HI_RST 8'h7F
`define TM_LO_RST 8'hC9

// configuration fields
`define TM_CFG_MASK 7
`define TM_CFG_STANDBY 6
`define TM_RATE_MAX 3'h7

// flag vector positions, status bits 6..2
`define TM_FLG_LHIGH 4
`define TM_FLG_LOCAL_LOW 3
`define TM_FLG_RHIGH 2
`define TM_FLG_REMOTE_LOW 1
`define TM_FLG_OPEN 0

// interrupt status positions
`define TM_IRQ_DONE 0
`define TM_IRQ_ALERT 1

// converter frame: eight data bits msb first, then the open-sensor bit
`define TM_FRAME_BITS 4'h9
// averaging depth as a power of two
`define TM_AVG_LOG2 4
// cycles of the conversion-rate unit
`define TM_RATE_UNIT_CYC 4096

`endif

// >>> tmon_pkg.sv
// Purpose: types shared by the temperature monitor
// Assumes: tmon_map.svh on the include path
// Notes: widths follow the 8-bit value format
package tmon_pkg;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_CONV = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } regbus_req_t;

   typedef struct packed {
      logic signed [11:0] sum;
      logic [7:0] mean;
      logic done;
   } avg_state_t;

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
      logic frm_s1;
      logic frm_s2;
      logic din_s1;
      logic din_s2;
      logic sbp_s1;
      logic sbp_s2;
      seq_state_t state;
      logic chan;
      logic [3:0] round;
      logic [3:0] bitcnt;
      logic [8:0] shreg;
      logic [23:0] wait_cnt;
      logic armed;
      logic [7:0] cfg;
      logic [7:0] rate;
      logic [7:0] lhi;
      logic [7:0] llo;
      logic [7:0] rhi;
      logic [7:0] rlo;
      logic [7:0] lval;
      logic [7:0] rval;
      logic open_cond;
      logic [4:0] flags;
      logic alert;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic [7:0] rdata;
   } mon_state_t;

endpackage

// >>> sample_averager.sv
// Purpose: sums a fixed number of signed samples and yields their mean
// Assumes: one add pulse per sample, last flagged on the final one
// Notes: clear drops a partial sum
`include "tmon_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sample_averager #(
   parameter int AVG_LOG2 = `TM_AVG_LOG2
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_clr,
   input wire logic i_add,
   input wire logic i_last,
   input wire logic [7:0] i_sample,
   output logic [7:0] o_mean,
   output logic o_done
);

   tmon_pkg::avg_state_t st_reg;
   tmon_pkg::avg_state_t st_next;
   logic signed [11:0] total;

   // sum is twelve bits wide, enough for sixteen samples
   generate
      if (AVG_LOG2 < 1 || AVG_LOG2 > `TM_AVG_LOG2) begin : g_chk
         $error("sample_averager: AVG_LOG2 out of range");
      end
   endgenerate

   // accumulate, and on the last sample shift down to the mean
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      total = st_reg.sum + {{4{i_sample[7]}}, i_sample};
      if (i_clr) begin
         st_next.sum = '0;
      end else if (i_add) begin
         if (i_last) begin
            st_next.sum = '0;
            st_next.mean = 8'(total >>> AVG_LOG2);
            st_next.done = 1'b1;
         end else begin
            st_next.sum = total;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg.sum <= '0;
         st_reg.mean <= `TM_VAL_RST;
         st_reg.done <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_mean = st_reg.mean;
   assign o_done = st_reg.done;

endmodule
`default_nettype wire

// >>> temp_limit_monitor.sv
// Purpose: sequences a two-channel temperature measurement and checks the results against limits
// Assumes: converter sends framed serial results on its own slow clock
// Notes: converter and standby pins pass two flip-flops before use; bus pins are used directly
`include "tmon_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - converter restarts by itself, no trigger
// - alternate local and remote sensor
// - each result stored as 8-bit two's complement
// - compare results against four limit registers
// - out-of-limit flags; alert low while present
// - host programs; every register reads back
// - standby, alert mask and rate controls
// - values reset to minus 128 degrees
// - first comparison only after both stored
// - standby power-up compares defaults, alert asserts
// - leave standby, read status clears if in-limit
// - average sixteen measurements before storing
// - status read clears flags unless cause persists
// - any flag sets alert latch
// - mask suppresses current and future alerts
module temp_limit_monitor #(
   parameter int RATE_UNIT_CYC = `TM_RATE_UNIT_CYC,
   parameter int AVG_LOG2 = `TM_AVG_LOG2
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RSTN,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire logic I_STANDBY_SELECT_PIN,
   input wire logic I_ADC_CLK,
   input wire logic I_ADC_FRAME,
   input wire logic I_ADC_DIN,
   output logic O_ADC_REQ,
   output logic O_ADC_SEL,
   output logic O_ALERT_O,
   output logic O_ALERT_OE_N,
   output logic O_IRQ
);

   tmon_pkg::mon_state_t st;
   tmon_pkg::mon_state_t nx;
   tmon_pkg::regbus_req_t bus;
   logic standby;
   logic clk_rise;
   logic sample_done;
   logic last_round;
   logic avg_clr;
   logic stat_rd;
   logic [2:0] rate_sel;
   logic [23:0] period;
   logic [4:0] cond;
   logic [1:0] irq_clr;
   logic [1:0] irq_ev;
   logic [7:0] mean [2];
   logic done [2];
   logic local_under_limit_flag;
   logic remote_under_limit_flag;

   // the rate counter must hold the longest wait
   generate
      if (RATE_UNIT_CYC < 1 || RATE_UNIT_CYC > 131071) begin : g_chk_rate
         $error("temp_limit_monitor: RATE_UNIT_CYC out of range");
      end
      if (AVG_LOG2 < 1 || AVG_LOG2 > `TM_AVG_LOG2) begin : g_chk_avg
         $error("temp_limit_monitor: AVG_LOG2 out of range");
      end
   endgenerate

   // bus strobes gathered into one carrier
   assign bus = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

   // pin low or control bit set puts the part in standby
   assign standby = !st.sbp_s2 || st.cfg[`TM_CFG_STANDBY];
   assign clk_rise = st.clk_s2 && !st.clk_s3;
   // ninth bit of a frame closes the sample
   assign sample_done = (st.state == tmon_pkg::ST_CONV) && !standby && st.frm_s2 && clk_rise
                        && (st.bitcnt == `TM_FRAME_BITS - 4'h1);
   assign last_round = (st.round == 4'((1 << AVG_LOG2) - 1));
   assign avg_clr = (st.state == tmon_pkg::ST_CONV) && standby;

   // wait between cycles doubles for each step down in rate
   assign rate_sel = (st.rate > 8'(`TM_RATE_MAX)) ? `TM_RATE_MAX : st.rate[2:0];
   assign period = 24'(RATE_UNIT_CYC) << (`TM_RATE_MAX - rate_sel);

   // live limit comparisons, held off until armed
   always_comb begin
      cond = 5'h00;
      if (st.armed) begin
         cond[`TM_FLG_LHIGH] = $signed(st.lval) > $signed(st.lhi);
         cond[`TM_FLG_LOCAL_LOW] = $signed(st.lval) < $signed(st.llo);
         cond[`TM_FLG_RHIGH] = $signed(st.rval) > $signed(st.rhi);
         cond[`TM_FLG_REMOTE_LOW] = $signed(st.rval) < $signed(st.rlo);
         cond[`TM_FLG_OPEN] = st.open_cond;
      end
   end

   assign stat_rd = bus.rd && (bus.addr == `TM_RD_STATUS);
   assign irq_clr = (bus.wr && (bus.addr == `TM_IRQ_CLR)) ? bus.wdata[1:0] : 2'h0;
   assign local_under_limit_flag = st.flags[`TM_FLG_LOCAL_LOW];
   assign remote_under_limit_flag = st.flags[`TM_FLG_REMOTE_LOW];

   // one averager per channel
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_avg
         sample_averager #(
            .AVG_LOG2(AVG_LOG2)
         ) u_avg (
            .i_clk(I_CLK_SYS),
            .i_rstn(I_RSTN),
            .i_clr(avg_clr),
            .i_add(sample_done && (st.chan == 1'(g))),
            .i_last(last_round),
            .i_sample(st.shreg[7:0]),
            .o_mean(mean[g]),
            .o_done(done[g])
         );
      end
   endgenerate

   // next state of the whole block
   always_comb begin
      nx = st;
      irq_ev = 2'h0;
      nx.rdata = 8'h00;
      // two-stage synchronisers, plus one stage for edge finding
      nx.clk_s1 = I_ADC_CLK;
      nx.clk_s2 = st.clk_s1;
      nx.clk_s3 = st.clk_s2;
      nx.frm_s1 = I_ADC_FRAME;
      nx.frm_s2 = st.frm_s1;
      nx.din_s1 = I_ADC_DIN;
      nx.din_s2 = st.din_s1;
      nx.sbp_s1 = I_STANDBY_SELECT_PIN;
      nx.sbp_s2 = st.sbp_s1;
      // frame shift register
      if (!st.frm_s2) begin
         nx.bitcnt = 4'h0;
      end else if (clk_rise && st.bitcnt < `TM_FRAME_BITS) begin
         nx.shreg = {st.shreg[7:0], st.din_s2};
         nx.bitcnt = st.bitcnt + 4'h1;
      end
      // measurement sequencer
      case (st.state)
         tmon_pkg::ST_WAIT: begin
            if (standby) begin
               nx.wait_cnt = 24'h000000;
            end else if (st.wait_cnt >= period - 24'h000001) begin
               nx.state = tmon_pkg::ST_CONV;
               nx.wait_cnt = 24'h000000;
               nx.chan = 1'b0;
               nx.round = 4'h0;
            end else begin
               nx.wait_cnt = st.wait_cnt + 24'h000001;
            end
         end
         tmon_pkg::ST_CONV: begin
            if (standby) begin
               nx.state = tmon_pkg::ST_WAIT;
               nx.chan = 1'b0;
               nx.round = 4'h0;
            end else if (sample_done) begin
               nx.chan = !st.chan;
               if (st.chan) begin
                  nx.round = st.round + 4'h1;
                  if (last_round) begin
                     nx.open_cond = st.din_s2;
                     nx.state = tmon_pkg::ST_WAIT;
                  end
               end
            end
         end
         default: begin
            nx.state = tmon_pkg::ST_WAIT;
         end
      endcase
      // store averaged results
      if (done[0]) begin
         nx.lval = mean[0];
      end
      if (done[1]) begin
         nx.rval = mean[1];
         nx.armed = 1'b1;
         irq_ev[`TM_IRQ_DONE] = 1'b1;
      end
      if (standby) begin
         nx.armed = 1'b1;
      end
      // register writes
      if (bus.wr) begin
         if (bus.addr == `TM_WR_CFG) begin
            nx.cfg = bus.wdata;
         end else if (bus.addr == `TM_WR_RATE) begin
            nx.rate = bus.wdata;
         end else if (bus.addr == `TM_WR_LHI) begin
            nx.lhi = bus.wdata;
         end else if (bus.addr == `TM_WR_LLO) begin
            nx.llo = bus.wdata;
         end else if (bus.addr == `TM_WR_RHI) begin
            nx.rhi = bus.wdata;
         end else if (bus.addr == `TM_WR_RLO) begin
            nx.rlo = bus.wdata;
         end else if (bus.addr == `TM_IRQ_EN) begin
            nx.irq_en = bus.wdata[1:0];
         end
      end
      // a present cause beats the read clear
      nx.flags = (st.flags & ~{5{stat_rd}}) | cond;
      nx.alert = (|nx.flags) && !nx.cfg[`TM_CFG_MASK];
      irq_ev[`TM_IRQ_ALERT] = nx.alert && !st.alert;
      nx.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
      // read-back, valid the cycle after the strobe
      if (bus.rd) begin
         if (bus.addr == `TM_RD_LVAL) begin
            nx.rdata = st.lval;
         end else if (bus.addr == `TM_RD_RVAL) begin
            nx.rdata = st.rval;
         end else if (bus.addr == `TM_RD_STATUS) begin
            nx.rdata = {(st.state == tmon_pkg::ST_CONV), st.flags, 2'b00};
         end else if (bus.addr == `TM_RD_CFG) begin
            nx.rdata = st.cfg;
         end else if (bus.addr == `TM_RD_RATE) begin
            nx.rdata = st.rate;
         end else if (bus.addr == `TM_RD_LHI) begin
            nx.rdata = st.lhi;
         end else if (bus.addr == `TM_RD_LLO) begin
            nx.rdata = st.llo;
         end else if (bus.addr == `TM_RD_RHI) begin
            nx.rdata = st.rhi;
         end else if (bus.addr == `TM_RD_RLO) begin
            nx.rdata = st.rlo;
         end else if (bus.addr == `TM_IRQ_STAT) begin
            nx.rdata = {6'h00, st.irq_stat};
         end else if (bus.addr == `TM_IRQ_EN) begin
            nx.rdata = {6'h00, st.irq_en};
         end
      end
   end

   // state register; power-up starts converting at once
   always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st <= '0;
         st.sbp_s1 <= 1'b1;
         st.sbp_s2 <= 1'b1;
         st.state <= tmon_pkg::ST_CONV;
         st.cfg <= `TM_CFG_RST;
         st.rate <= `TM_RATE_RST;
         st.lhi <= `TM_HI_RST;
         st.llo <= `TM_LO_RST;
         st.rhi <= `TM_HI_RST;
         st.rlo <= `TM_LO_RST;
         st.lval <= `TM_VAL_RST;
         st.rval <= `TM_VAL_RST;
      end else begin
         st <= nx;
      end
   end

   // outputs
   assign O_RDATA = st.rdata;
   assign O_ADC_REQ = (st.state == tmon_pkg::ST_CONV);
   assign O_ADC_SEL = st.chan;
   assign O_ALERT_O = 1'b0;
   assign O_ALERT_OE_N = !st.alert;
   assign O_IRQ = |(st.irq_stat & st.irq_en);

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RSTN);

   AST_POWERUP_VAL: assert property (!st.armed |-> st.rval == `TM_VAL_RST)
      else $error("remote value changed before arming");
   AST_FREE_RUN: assert property ((st.state == tmon_pkg::ST_WAIT) && !standby
      && (st.wait_cnt == period - 24'h000001) |=> O_ADC_REQ)
      else $error("conversion did not restart");
   AST_ALTERNATE: assert property (sample_done |=> O_ADC_SEL != $past(O_ADC_SEL))
      else $error("channel did not alternate");
   AST_STORE: assert property (done[1] |=> st.rval == $past(mean[1]))
      else $error("remote mean not stored");
   AST_LOW_FLAG: assert property (cond[`TM_FLG_LOCAL_LOW] |=> local_under_limit_flag)
      else $error("local low flag not set");
   AST_ALERT_PIN: assert property ((|st.flags) && !st.cfg[`TM_CFG_MASK] |-> !O_ALERT_OE_N)
      else $error("alert not driven with flag set");
   AST_MASK: assert property (st.cfg[`TM_CFG_MASK] |-> O_ALERT_OE_N)
      else $error("masked alert still driven");
   AST_CLEAR: assert property (stat_rd && (cond == 5'h00) |=> st.flags == 5'h00)
      else $error("status read left flags set");
   AST_HOLD: assert property (remote_under_limit_flag && !stat_rd |=> remote_under_limit_flag)
      else $error("remote low flag lost without read");
   AST_STANDBY: assert property (standby && (st.state == tmon_pkg::ST_WAIT)
      |=> (st.state == tmon_pkg::ST_WAIT) && $stable(st.rval))
      else $error("conversion ran in standby");
   AST_NO_EARLY: assert property (!st.armed |-> st.flags == 5'h00)
      else $error("flag set before arming");
   AST_READBACK: assert property (bus.rd && (bus.addr == `TM_RD_LHI) ##1 1'b1
      |-> O_RDATA == $past(st.lhi))
      else $error("limit read-back wrong");

endmodule
`default_nettype wire

// >>> adc_link_model.sv
// Purpose: converter model that answers each channel request with one framed serial result
// Assumes: link clock half period of HALF_NS; the link clock stands still between frames
// Notes: each channel alternates base and base+3, so a 16-sample mean reads base+1
`timescale 1ns/1ps
`default_nettype none

module adc_link_model #(
   parameter int HALF_NS = 160
) (
   input wire logic i_req,
   input wire logic i_sel,
   input wire logic [7:0] i_lbase,
   input wire logic [7:0] i_rbase,
   input wire logic i_open,
   output logic o_clk,
   output logic o_frame,
   output logic o_din
);
   logic [8:0] word;
   logic [1:0] tog;
   logic ch;
   int i;

   // one frame for the wanted channel, then wait until the channel moves on
   initial begin
      o_clk = 1'b0;
      o_frame = 1'b0;
      o_din = 1'b0;
      tog = 2'b00;
      forever begin
         wait (i_req === 1'b1);
         #(HALF_NS);
         if (i_req === 1'b1) begin
            ch = i_sel;
            word = {(ch ? i_rbase : i_lbase) + (tog[ch] ? 8'h03 : 8'h00), ch & i_open};
            tog[ch] = ~tog[ch];
            o_frame = 1'b1;
            for (i = 8; i >= 0; i--) begin
               o_din = word[i];
               #(HALF_NS) o_clk = 1'b1;
               #(HALF_NS) o_clk = 1'b0;
            end
            o_frame = 1'b0;
            o_din = ~o_din; // released line shows no stale bit
            for (i = 0; i < 60 && i_sel === ch && i_req === 1'b1; i++) #40;
         end
      end
   end
endmodule

`default_nettype wire

// >>> tb_temp_limit_monitor.sv
// Purpose: self-checking bench for the two-channel temperature limit monitor
// Assumes: tmon_map.svh on the include path; converter model beside it
// Notes: reads are scored from a queue of expected bytes; pins are checked in place
`include "tmon_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_temp_limit_monitor;
   logic I_CLK_SYS = 1'b0;
   logic I_RSTN = 1'b0;
   logic [7:0] I_ADDR = 8'h00;
   logic [7:0] I_WDATA = 8'h00;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic I_STANDBY_SELECT_PIN = 1'b1;
   logic adc_clk, adc_frame, adc_din;
   logic [7:0] O_RDATA;
   logic O_ADC_REQ, O_ADC_SEL, O_ALERT_O, O_ALERT_OE_N, O_IRQ;
   logic [7:0] exp_q[$];
   logic [7:0] adr_q[$];
   logic [7:0] e, a, v, lb, rb;
   logic rd_seen = 1'b0;
   logic alert_low = 1'b0;
   logic open_bit = 1'b0;
   int n_mismatch = 0;
   int n_compared = 0;
   int k;
   integer seed = 32'h5efc;
   wire logic alert_line = (O_ALERT_OE_N === 1'b0) ? O_ALERT_O : 1'b1; // pulled up when released

   // 25 MHz system clock
   always #20 I_CLK_SYS = ~I_CLK_SYS;

   temp_limit_monitor #(.RATE_UNIT_CYC(4), .AVG_LOG2(`TM_AVG_LOG2)) dut (
      .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
      .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_STANDBY_SELECT_PIN(I_STANDBY_SELECT_PIN),
      .I_ADC_CLK(adc_clk), .I_ADC_FRAME(adc_frame), .I_ADC_DIN(adc_din), .O_ADC_REQ(O_ADC_REQ),
      .O_ADC_SEL(O_ADC_SEL), .O_ALERT_O(O_ALERT_O), .O_ALERT_OE_N(O_ALERT_OE_N), .O_IRQ(O_IRQ)
   );

   adc_link_model #(.HALF_NS(160)) adc (
      .i_req(O_ADC_REQ), .i_sel(O_ADC_SEL), .i_lbase(lb), .i_rbase(rb), .i_open(open_bit),
      .o_clk(adc_clk), .o_frame(adc_frame), .o_din(adc_din)
   );

   // score each read in the cycle its data stands; idle data must be zero
   always @(posedge I_CLK_SYS) begin
      if (rd_seen) begin
         e = exp_q.pop_front();
         a = adr_q.pop_front();
         n_compared++;
         if (O_RDATA !== e) begin
            n_mismatch++;
            $display("[FAIL] rdata %h exp %h got %h", a, e, O_RDATA);
         end
      end else if (I_RSTN && O_RDATA !== 8'h00) begin
         n_mismatch++;
         $display("[FAIL] idle rdata exp 00 got %h", O_RDATA);
      end
      if (O_ALERT_OE_N === 1'b0) alert_low <= 1'b1;
      rd_seen <= I_RD;
   end

   task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
      I_WR <= w;
      I_RD <= ~w;
      I_ADDR <= ad;
      I_WDATA <= d;
      @(posedge I_CLK_SYS);
      I_WR <= 1'b0;
      I_RD <= 1'b0;
      @(posedge I_CLK_SYS);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      acc(1'b1, ad, d);
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
      exp_q.push_back(ex);
      adr_q.push_back(ad);
      acc(1'b0, ad, 8'h00);
   endtask

   task automatic chk(input string nm, input logic ex, input logic g);
      n_compared++;
      if (g !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s exp %b got %b", nm, ex, g);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge I_CLK_SYS);
   endtask

   // wait for the remote result of the next measurement cycle to be stored
   task automatic wait_done;
      int w;
      wr(`TM_IRQ_CLR, 8'h01);
      wr(`TM_IRQ_EN, 8'h01);
      for (w = 0; w < 8000 && O_IRQ !== 1'b1; w++) @(posedge I_CLK_SYS);
      chk("cycle done", 1'b1, O_IRQ);
   endtask

   task automatic reset_dut(input logic pin);
      I_STANDBY_SELECT_PIN <= pin;
      I_RSTN <= 1'b0;
      cycles(2);
      I_RSTN <= 1'b1;
      @(posedge I_CLK_SYS);
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // cut a hang short well beyond the expected run of about 11000 cycles
   initial begin
      cycles(60000);
      n_mismatch++;
      $display("[FAIL] watchdog exp finish got timeout");
      results();
   end

   // main sequence
   initial begin
      lb = 8'd20 + {2'b00, 6'($random(seed))};
      rb = lb + 8'd5;
      reset_dut(1'b1);
      chk("req at power-up", 1'b1, O_ADC_REQ);
      chk("local first", 1'b0, O_ADC_SEL);
      rd(`TM_RD_LVAL, `TM_VAL_RST);
      rd(`TM_RD_RVAL, `TM_VAL_RST);
      rd(`TM_RD_STATUS, 8'h80);
      rd(`TM_RD_CFG, `TM_CFG_RST);
      rd(`TM_RD_RATE, `TM_RATE_RST);
      rd(`TM_RD_LLO, `TM_LO_RST);
      rd(`TM_RD_RHI, `TM_HI_RST);
      rd(`TM_WR_LHI, 8'h00);
      rd(8'h3C, 8'h00);
      wr(`TM_RD_LVAL, 8'h11);
      rd(`TM_RD_LVAL, `TM_VAL_RST);
      wr(`TM_WR_RATE, 8'h05);
      rd(`TM_RD_RATE, 8'h05);
      wr(`TM_WR_RATE, `TM_RATE_RST);
      for (k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         wr(`TM_WR_LHI + 8'(k), v);
         rd(`TM_RD_LHI + 8'(k), v);
         wr(`TM_WR_LHI + 8'(k), k[0] ? `TM_LO_RST : `TM_HI_RST);
      end
      $display("test power-up done");
      alert_low = 1'b0;
      wait_done();
      rd(`TM_RD_LVAL, lb + 8'd1);
      rd(`TM_RD_RVAL, rb + 8'd1);
      rd(`TM_RD_STATUS, 8'h00);
      chk("no alert before store", 1'b0, alert_low);
      $display("test first cycle done");
      wr(`TM_WR_LHI, lb);
      wr(`TM_WR_RLO, rb + 8'd2);
      open_bit = 1'b1;
      wait_done();
      wr(`TM_WR_CFG, 8'h40);
      rd(`TM_RD_CFG, 8'h40);
      rd(`TM_RD_STATUS, 8'h4C);
      rd(`TM_RD_STATUS, 8'h4C);
      chk("alert low", 1'b0, alert_line);
      wr(`TM_WR_CFG, 8'hC0);
      cycles(3);
      chk("alert masked", 1'b1, alert_line);
      wr(`TM_WR_CFG, 8'h40);
      cycles(3);
      chk("alert unmasked", 1'b0, alert_line);
      rd(`TM_IRQ_STAT, 8'h03);
      wr(`TM_IRQ_CLR, 8'h01);
      wr(`TM_IRQ_EN, 8'h02);
      chk("irq alert", 1'b1, O_IRQ);
      wr(`TM_IRQ_CLR, 8'h02);
      chk("irq cleared", 1'b0, O_IRQ);
      rd(`TM_IRQ_STAT, 8'h00);
      wr(`TM_WR_LHI, `TM_HI_RST);
      wr(`TM_WR_RLO, `TM_LO_RST);
      cycles(3);
      rd(`TM_RD_STATUS, 8'h4C);
      rd(`TM_RD_STATUS, 8'h04);
      open_bit = 1'b0;
      lb = lb + 8'd7;
      rb = rb + 8'd7;
      cycles(300);
      chk("standby stops", 1'b0, O_ADC_REQ);
      rd(`TM_RD_LVAL, lb - 8'd6);
      wr(`TM_WR_CFG, 8'h00);
      wait_done();
      wr(`TM_WR_CFG, 8'h40);
      rd(`TM_RD_LVAL, lb + 8'd1);
      rd(`TM_RD_STATUS, 8'h04);
      rd(`TM_RD_STATUS, 8'h00);
      cycles(3);
      chk("alert released", 1'b1, alert_line);
      $display("test limits done");
      reset_dut(1'b0);
      cycles(100);
      chk("standby alert", 1'b0, alert_line);
      chk("standby idle", 1'b0, O_ADC_REQ);
      rd(`TM_RD_STATUS, 8'h28);
      wr(`TM_WR_LLO, 8'h80);
      wr(`TM_WR_RLO, 8'h80);
      rd(`TM_RD_STATUS, 8'h28);
      rd(`TM_RD_STATUS, 8'h00);
      cycles(3);
      chk("alert cleared", 1'b1, alert_line);
      reset_dut(1'b0);
      cycles(100);
      I_STANDBY_SELECT_PIN <= 1'b1;
      wait_done();
      rd(`TM_RD_STATUS, 8'h28);
      rd(`TM_RD_STATUS, 8'h00);
      cycles(3);
      chk("alert after wake", 1'b1, alert_line);
      rd(`TM_RD_RVAL, rb + 8'd1);
      $display("test standby power-up done");
      cycles(3);
      results();
   end
endmodule

`default_nettype wire
